/* rx_guard_mod_ctrl.v */
// Receive guard timer and modulator / clock output control with APB slave
`timescale 1ns/1ps
`include "rx_guard_mod_regs.vh"

module rx_guard_mod_ctrl #(
  parameter STEP_CYCLES = `GUARD_STEP_NS / `CLK_PERIOD_NS,
  parameter OSC_DIV     = 1
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Chip enable pin, active high
  input  wire        chip_enable_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [7:0]  paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Transmit frame end and receive path
  input  wire        tx_eof_i,
  output reg         rx_decoder_reset_o,
  // Modulator pins
  input  wire        ook_select_pin_i,
  input  wire        mod_pin_i,
  input  wire        mod_internal_i,
  output reg         mod_signal_o,
  output reg         mod_is_ook_o,
  output reg  [2:0]  mod_depth_o,
  output reg         double_rate_crystal_enable_o,
  // Clock output
  output reg         host_clock_output_o
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Pins are asynchronous to clk_sys_i; only the second stage is read
  localparam NUM_SYNC = 3;

  wire [NUM_SYNC-1:0] pin_raw = {mod_pin_i, ook_select_pin_i, chip_enable_i};
  wire [NUM_SYNC-1:0] pin_sync;

  genvar g;
  generate
    for (g = 0; g < NUM_SYNC; g = g + 1) begin : g_sync
      reg meta_q;
      reg stable_q;

      // Reset low: enable reads as off until two edges have passed
      always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
          meta_q   <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q   <= pin_raw[g];
          stable_q <= meta_q;
        end
      end

      assign pin_sync[g] = stable_q;
    end
  endgenerate

  wire chip_on   = pin_sync[0];
  wire ook_pin_s = pin_sync[1];
  wire mod_pin_s = pin_sync[2];

  // ----------------------------------------
  // Guard preset decode
  // ----------------------------------------
  function [7:0] guard_preset;
    input [4:0] code;
    begin
      if (code == `PROTO_CODE_ONE_STEP)
        guard_preset = `GUARD_PRESET_ONE;                     // see RULE5
      else if (code >= `PROTO_CODE_14443_LO && code <= `PROTO_CODE_14443_HI)
        guard_preset = `GUARD_PRESET_14443;                   // see RULE5
      else if (code <= `PROTO_CODE_15693_HI)
        guard_preset = `GUARD_PRESET_15693;                   // see RULE5
      else
        guard_preset = `RX_GUARD_RST;
    end
  endfunction

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  // Word index compare, shared by every register select below
  function idx_hit;
    input [7:0] idx;
    input [7:0] target;
    begin
      idx_hit = (idx == target);
    end
  endfunction

  // Addresses outside the map simply fail to match
  wire       apb_acc   = psel_i & penable_i;
  wire       apb_wr    = apb_acc & pwrite_i;
  wire [7:0] apb_idx   = {2'h0, paddr_i[7:2]};
  wire       hit_proto = idx_hit(apb_idx, `IDX_PROTOCOL_SELECT);
  wire       hit_guard = idx_hit(apb_idx, `IDX_RX_GUARD);
  wire       hit_mod   = idx_hit(apb_idx, `IDX_MOD_CLK);
  wire       hit_stat  = idx_hit(apb_idx, `IDX_STATUS);
  wire       hit_any   = hit_proto | hit_guard | hit_mod | hit_stat;
  wire       unaligned = (paddr_i[1:0] != 2'h0);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Enable low holds all three at reset values
  reg  [7:0] protocol_q;
  reg  [7:0] protocol_d;
  reg  [7:0] rx_guard_q;
  reg  [7:0] rx_guard_d;
  reg  [7:0] mod_clk_q;
  reg  [7:0] mod_clk_d;
  wire       wr_ok = apb_wr & ~unaligned;

  always @* begin
    protocol_d = protocol_q;
    rx_guard_d = rx_guard_q;
    mod_clk_d  = mod_clk_q;
    if (!chip_on) begin
      protocol_d = `PROTOCOL_RST;
      rx_guard_d = `RX_GUARD_RST;                              // see RULE4
      mod_clk_d  = `MOD_CLK_RST;                               // see RULE14
    end else if (wr_ok && hit_proto) begin
      // Divider bits survive so the host clock does not glitch
      protocol_d = pwdata_i[7:0];
      rx_guard_d = guard_preset(pwdata_i[`PROTO_FIELD_MSB:0]); // see RULE2
      mod_clk_d  = (`MOD_CLK_RST & ~`MOD_CLKDIV_MASK)
                 | (mod_clk_q & `MOD_CLKDIV_MASK);            // see RULE14
    end else if (wr_ok && hit_guard) begin
      rx_guard_d = pwdata_i[7:0];                              // see RULE3
    end else if (wr_ok && hit_mod) begin
      mod_clk_d = pwdata_i[7:0];
    end
  end

  // Write lands at the access edge, the same edge that sees pready
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      protocol_q <= `PROTOCOL_RST;
      rx_guard_q <= `RX_GUARD_RST;                              // see RULE4
      mod_clk_q  <= `MOD_CLK_RST;                               // see RULE14
    end else begin
      protocol_q <= protocol_d;
      rx_guard_q <= rx_guard_d;
      mod_clk_q  <= mod_clk_d;
    end
  end

  // ----------------------------------------
  // APB response, zero wait states
  // ----------------------------------------
  // Ready follows every setup cycle, so the access phase never stretches
  reg        guard_busy_q;
  reg [31:0] rdata_d;
  wire       setup_phase = psel_i & ~penable_i;
  wire       refused     = ~hit_any | unaligned;

  // Refused reads return zero rather than a neighbouring register
  always @* begin
    rdata_d = 32'h0;
    if (setup_phase && !pwrite_i && !refused) begin
      if (hit_proto)
        rdata_d = {24'h0, protocol_q};
      else if (hit_guard)
        rdata_d = {24'h0, rx_guard_q};
      else if (hit_mod)
        rdata_d = {24'h0, mod_clk_q};
      else if (hit_stat)
        rdata_d = {31'h0, guard_busy_q};
    end
  end

  // Registered outputs, valid during the access cycle
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o  <= 32'h0;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= setup_phase;
      pslverr_o <= setup_phase & refused;
      prdata_o  <= rdata_d;
    end
  end

  // ----------------------------------------
  // Receive guard timer
  // ----------------------------------------
  // Count latched at frame end so a mid-guard write cannot stretch it
  localparam ST_IDLE = 2'b01;
  localparam ST_HOLD = 2'b10;

  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [31:0] step_cnt_q;
  reg [31:0] step_cnt_d;
  reg [7:0]  steps_left_q;
  reg [7:0]  steps_left_d;

  wire guard_armed = (rx_guard_q != 8'h0);
  wire step_done   = (step_cnt_q == STEP_CYCLES - 1);
  wire last_step   = step_done & (steps_left_q == 8'h1);

  always @* begin
    state_d      = state_q;
    step_cnt_d   = step_cnt_q;
    steps_left_d = steps_left_q;
    if (!chip_on) begin
      state_d      = ST_IDLE;
      step_cnt_d   = 32'h0;
      steps_left_d = 8'h0;
    end else if (tx_eof_i) begin
      // A new frame end restarts the guard from the current register
      state_d      = guard_armed ? ST_HOLD : ST_IDLE;       // see RULE15
      step_cnt_d   = 32'h0;
      steps_left_d = rx_guard_q;                            // see RULE1
    end else begin
      case (state_q)
        ST_IDLE: begin
          step_cnt_d = 32'h0;
        end
        ST_HOLD: begin
          if (step_done) begin
            step_cnt_d   = 32'h0;
            steps_left_d = steps_left_q - 8'h1;
            if (last_step)
              state_d = ST_IDLE;                            // see RULE1
          end else begin
            step_cnt_d = step_cnt_q + 32'h1;
          end
        end
        default: begin
          // Illegal code: fall back to idle
          state_d    = ST_IDLE;
          step_cnt_d = 32'h0;
        end
      endcase
    end
  end

  // Busy flag mirrors the next state so status reads match the pin while enabled
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= ST_IDLE;
      step_cnt_q   <= 32'h0;
      steps_left_q <= 8'h0;
      guard_busy_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      step_cnt_q   <= step_cnt_d;
      steps_left_q <= steps_left_d;
      guard_busy_q <= (state_d == ST_HOLD);
    end
  end

  // Decoders held during guard or while disabled
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i)
      rx_decoder_reset_o <= 1'b1;
    else
      rx_decoder_reset_o <= ~chip_on | (state_d == ST_HOLD);     // see RULE1
  end

  // ----------------------------------------
  // Modulator control
  // ----------------------------------------
  // Both enables must be set, so a stray pin level cannot take over
  wire       ext_sel     = mod_clk_q[`BIT_EXT_OOK_EN] & protocol_q[`BIT_PROTO_EXT]; // see RULE11
  wire [2:0] depth_field = mod_clk_q[`BIT_DEPTH_MSB:0];
  reg        mod_signal_d;
  reg        mod_is_ook_d;

  always @* begin
    if (ext_sel) begin
      mod_signal_d = mod_pin_s;                                 // see RULE12
      mod_is_ook_d = ook_pin_s;                                 // see RULE13
    end else begin
      mod_signal_d = mod_internal_i;
      mod_is_ook_d = (depth_field == `DEPTH_OOK);               // see RULE10
    end
  end

  // Pins are already two flops deep; one more stage for the output
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mod_signal_o                 <= 1'b0;
      mod_is_ook_o                 <= 1'b0;
      mod_depth_o                  <= 3'h0;
      double_rate_crystal_enable_o <= 1'b0;
    end else begin
      mod_signal_o                 <= mod_signal_d;
      mod_is_ook_o                 <= mod_is_ook_d;
      mod_depth_o                  <= depth_field;              // see RULE9
      double_rate_crystal_enable_o <= mod_clk_q[`BIT_DBL_XTAL];
    end
  end

  // ----------------------------------------
  // Clock output divider
  // ----------------------------------------
  // Oscillator modelled as an enable every OSC_DIV system cycles; each
  // tick is one oscillator half period, so bit 0 of the chain is osc / 1
  reg  [7:0] osc_cnt_q;
  reg  [2:0] div_q;
  reg        clkout_d;
  wire       osc_tick = (osc_cnt_q == OSC_DIV - 1);
  wire [1:0] div_sel  = mod_clk_q[`BIT_CLKDIV_HI:`BIT_CLKDIV_LO];

  // Code 00 parks the pin low
  always @* begin
    case (div_sel)                                              // see RULE6
      2'h0:    clkout_d = 1'b0;                                 // see RULE7
      2'h1:    clkout_d = div_q[2];                             // see RULE7
      2'h2:    clkout_d = div_q[1];                             // see RULE8
      2'h3:    clkout_d = div_q[0];                             // see RULE8
      default: clkout_d = 1'b0;
    endcase
  end

  // Updated only on ticks, so the output is a clean square wave
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_cnt_q           <= 8'h0;
      div_q               <= 3'h0;
      host_clock_output_o <= 1'b0;
    end else begin
      osc_cnt_q <= osc_tick ? 8'h0 : osc_cnt_q + 8'h1;
      if (osc_tick) begin
        div_q               <= div_q + 3'h1;
        host_clock_output_o <= clkout_d;
      end
    end
  end

endmodule // rx_guard_mod_ctrl

/* rx_guard_mod_regs.vh */
// Register map, field layout, reset values and timing constants
// Functional notes
// RULE1 - Hold decoders reset guard count times step
// RULE2 - Protocol write reloads guard with preset
// RULE3 - Guard field eight bits, counts 1..255
// RULE4 - Guard resets to 0x1f, also enable low
// RULE5 - Presets: one step, 66us, 293us
// RULE6 - Clock output divides oscillator by 1,2,4
// RULE7 - Divider bits 5:4; 00 off, 01 /4
// RULE8 - Divider 10 gives /2, 11 undivided
// RULE9 - Depth field bits 2:0 sets modulation depth
// RULE10 - Depths 7% to 30% ASK, plus OOK
// RULE11 - Pin select needs both bit6 flags set
// RULE12 - Pin mode: modulation input pin is source
// RULE13 - Select pin high OOK, low programmed ASK
// RULE14 - Mod reg 0x91; protocol write keeps divider
// RULE15 - Guard zero enables decoders at once
`ifndef RX_GUARD_MOD_REGS_VH
`define RX_GUARD_MOD_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses = index * 4)
// ----------------------------------------
`define IDX_PROTOCOL_SELECT   8'h01
`define IDX_RX_GUARD          8'h08
`define IDX_MOD_CLK           8'h09
`define IDX_STATUS            8'h0f

// ----------------------------------------
// Reset values and fields
// ----------------------------------------
`define RX_GUARD_RST          8'h1f
`define MOD_CLK_RST           8'h91
`define PROTOCOL_RST          8'h00
`define MOD_CLKDIV_MASK       8'h30
`define BIT_EXT_OOK_EN        6
`define BIT_DBL_XTAL          7
`define BIT_CLKDIV_HI         5
`define BIT_CLKDIV_LO         4
`define BIT_DEPTH_MSB         2
`define BIT_PROTO_EXT         6
`define DEPTH_OOK             3'h1

// ----------------------------------------
// Guard presets per protocol code (steps of 9.44 us)
// ----------------------------------------
`define PROTO_FIELD_MSB       4
`define PROTO_CODE_15693_LO   5'h00
`define PROTO_CODE_15693_HI   5'h07
`define PROTO_CODE_ONE_STEP   5'h1a
`define PROTO_CODE_14443_LO   5'h08
`define PROTO_CODE_14443_HI   5'h0f
`define GUARD_PRESET_ONE      8'h01
`define GUARD_PRESET_14443    8'h07
`define GUARD_PRESET_15693    8'h1f

// ----------------------------------------
// Timing
// ----------------------------------------
`define GUARD_STEP_NS         9440
`define CLK_PERIOD_NS         10

`endif

/* rx_guard_ctrl_asserts.sv */
// Port checks for the guard and modulator register block
`timescale 1ns/1ps
module rx_guard_ctrl_asserts #(
  parameter OSC_DIV = 1
) (
  // Watched ports
  input wire        clk_sys_i,
  input wire        rst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [7:0]  paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire        host_clock_output_o
);
  // Divider mirror; protocol writes keep it
  logic [1:0] div_q;
  logic [3:0] stab_q;
  logic       hco;
  assign hco = host_clock_output_o;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= 2'h1;
      stab_q <= 4'h0;
    end else if (pready_o && pwrite_i && paddr_i == 8'h24) begin
      div_q  <= pwdata_i[5:4];
      stab_q <= 4'h0;
    end else if (stab_q != 4'hf) begin
      stab_q <= stab_q + 4'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence setup_s;
    psel_i && !penable_i;
  endsequence
  a_ready_setup: assert property (setup_s |=> pready_o) else $error("no ready");
  a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready too long");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  a_err_rdzero: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0) else $error("bad data");
  a_misalign_err: assert property (setup_s and paddr_i[1:0] != 2'h0 |=> pslverr_o) else $error("no err");
  a_upper_zero: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0) else $error("upper");
  a_clk_off: assert property (stab_q == 4'hf && div_q == 2'h0 |-> !hco) else $error("clk on");
  a_clk_full: assert property (stab_q == 4'hf && div_q == 2'h3 |-> hco != $past(hco, OSC_DIV))
    else $error("div1");
  a_clk_half: assert property (stab_q == 4'hf && div_q == 2'h2 |-> hco != $past(hco, 2 * OSC_DIV))
    else $error("div2");
  a_clk_quarter: assert property (stab_q == 4'hf && div_q == 2'h1 |-> hco != $past(hco, 4 * OSC_DIV))
    else $error("div4");
endmodule // rx_guard_ctrl_asserts

/* host_apb_model.sv */
// Host controller model issuing APB transfers
`timescale 1ns/1ps
module host_apb_model (
  // Clock
  input  wire         clk_sys_i,
  // APB master
  output logic        psel_o,
  output logic        penable_o,
  output logic        pwrite_o,
  output logic [7:0]  paddr_o,
  output logic [31:0] pwdata_o,
  input  wire  [31:0] prdata_i,
  input  wire         pready_i,
  input  wire         pslverr_i
);
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 8'h0;
    pwdata_o  = 32'h0;
  end
  // Entered just after a rising edge; leaves one edge after release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e, output logic to);
    int   n;
    logic rdy;
    begin
      n = 0;
      psel_o    <= 1'b1;
      penable_o <= 1'b0;
      pwrite_o  <= w;
      paddr_o   <= a;
      pwdata_o  <= d;
      @(posedge clk_sys_i);
      penable_o <= 1'b1;
      // Sample at the rising edge, before the slave's updates land
      do begin
        @(posedge clk_sys_i);
        rdy = pready_i;
        r   = prdata_i;
        e   = pslverr_i;
        n++;
      end while (!rdy && n < 50);
      to = !rdy;
      // Stale bus values must not look valid
      psel_o    <= 1'b0;
      penable_o <= 1'b0;
      paddr_o   <= ~a;
      pwdata_o  <= ~d;
      @(posedge clk_sys_i);
    end
  endtask
endmodule // host_apb_model

/* rx_guard_and_modulator_control_tb.sv */
// Self-checking bench for the guard and modulator block
`timescale 1ns/1ps
module rx_guard_and_modulator_control_tb;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        chip_enable_i = 1'b1;
  logic        tx_eof_i = 1'b0;
  logic        ook_select_pin_i = 1'b0;
  logic        mod_pin_i = 1'b0;
  logic        mod_internal_i = 1'b0;
  wire         psel, penable, pwrite, pready, pslverr, rx_rst, mod_sig, mod_ook, dbl, clk_out;
  wire  [7:0]  paddr;
  wire  [31:0] pwdata, prdata;
  wire  [2:0]  depth;
  logic [31:0] r;
  logic        e, to, p;
  int          failures = 0, comparisons = 0, n;
  logic [7:0]  pc [3] = '{8'h00, 8'h08, 8'h1a};
  logic [7:0]  pp [3] = '{8'h1f, 8'h07, 8'h01};
  int          tg [4] = '{0, 4, 8, 16};
  rx_guard_mod_ctrl #(.STEP_CYCLES(4), .OSC_DIV(1)) rx_guard_mod_ctrl_inst (
    .clk_sys_i, .rst_i, .chip_enable_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .tx_eof_i, .rx_decoder_reset_o(rx_rst), .ook_select_pin_i, .mod_pin_i,
    .mod_internal_i, .mod_signal_o(mod_sig), .mod_is_ook_o(mod_ook), .mod_depth_o(depth),
    .double_rate_crystal_enable_o(dbl), .host_clock_output_o(clk_out));
  host_apb_model host_apb_model_inst (
    .clk_sys_i, .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
    .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task report_and_stop();
    if (failures == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [32:0] g, input logic [32:0] x);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    host_apb_model_inst.xfer(w, a, d, r, e, to);
    if (to) begin
      failures++;
      report_and_stop();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    acc(1'b0, a, 32'h0);
    chk({e, r}, {xe, x});
  endtask
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(8'h20, 32'h1f, 1'b0);
    rd(8'h24, 32'h91, 1'b0);
    chk({dbl, mod_ook, depth}, 5'h19);
    rd(8'h10, 32'h0, 1'b1);
    rd(8'h21, 32'h0, 1'b1);
    for (int i = 0; i < 2; i++) begin
      acc(1'b1, 8'h20, i ? 32'h0 : 32'h3);
      tx_eof_i <= 1'b1;
      @(posedge clk_sys_i);
      tx_eof_i <= 1'b0;
      n = 0;
      repeat (40) @(negedge clk_sys_i) n += rx_rst;
      @(posedge clk_sys_i);
      chk(n, i ? 0 : 12);
    end
    acc(1'b1, 8'h20, 32'hff);
    rd(8'h20, 32'hff, 1'b0);
    acc(1'b1, 8'h24, 32'h2a);
    for (int i = 0; i < 3; i++) begin
      acc(1'b1, 8'h04, {24'h0, pc[i]});
      rd(8'h20, {24'h0, pp[i]}, 1'b0);
    end
    rd(8'h24, 32'ha1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 8'h24, {26'h0, i[1:0], 4'h0});
      repeat (16) @(posedge clk_sys_i);
      n = 0;
      @(negedge clk_sys_i) p = clk_out;
      repeat (16) @(negedge clk_sys_i) begin
        n += (clk_out != p);
        p = clk_out;
      end
      @(posedge clk_sys_i);
      chk(n, tg[i]);
    end
    for (int i = 0; i < 8; i++) begin
      acc(1'b1, 8'h24, i);
      repeat (2) @(posedge clk_sys_i);
      chk({mod_ook, depth}, {i == 1, i[2:0]});
    end
    for (int j = 0; j < 2; j++) begin
      acc(1'b1, 8'h04, j ? 32'h0 : 32'h40);
      acc(1'b1, 8'h24, 32'h42);
      for (int i = 0; i < 4; i++) begin
        ook_select_pin_i <= i[0];
        mod_pin_i <= i[1];
        mod_internal_i <= ~i[1];
        repeat (5) @(posedge clk_sys_i);
        chk({mod_ook, mod_sig}, j ? {1'b0, ~i[1]} : {i[0], i[1]});
      end
    end
    acc(1'b1, 8'h24, 32'h10);
    acc(1'b1, 8'h20, 32'h5);
    chip_enable_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    acc(1'b1, 8'h20, 32'h9);
    chip_enable_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    rd(8'h20, 32'h1f, 1'b0);
    rd(8'h24, 32'h91, 1'b0);
    report_and_stop();
  end
endmodule // rx_guard_and_modulator_control_tb
bind rx_guard_mod_ctrl rx_guard_ctrl_asserts #(.OSC_DIV(OSC_DIV)) rx_guard_ctrl_asserts_inst (
  .clk_sys_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .host_clock_output_o);
